// File: rtl/pacing_timers.sv
// Pacing, burst and sample-stop timers of the acquisition block with an AXI4-Lite register slave.
//
// Notes on behaviour
// R1: Pacing clock is 24-bit down-counter, selectable source.
// R2: Pacing period equals divider plus one ticks.
// R3: Pacing divider writable at offset 040.
// R4: Divider write reloads counter and emits pulse.
// R5: Pacing primary clock selects 8 or 20 MHz.
// R6: Software keeps sampling rate at most 1.25 MHz.
// R7: Burst clock is separate 16-bit down-counter.
// R8: Burst divider writable at offset 044.
// R9: Burst divider write reloads and emits pulse.
// R10: Burst primary clock selected independently.
// R11: Burst divider accepts any value to 65535.
// R12: Stop counter loaded with samples minus one.
// R13: Stop counter expiry halts pacing when selected.
// R14: Cycle enable reloads stop counter, keeps sampling.
// R15: Cycle disable finishes current count then halts.
// R16: Stop counter zero raises an event pulse.
// R17: Software finishes setup before enabling interrupts.
// R18: Full buffer halts conversions, sets sticky flag.
// R19: Start write arms; earlier triggers ignored.
// R20: Counter at zero reloads and pulses once.
//
// Local design decision: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module pacing_timers import pacing_pkg::*; #(
   parameter int PACE_W  = 24,
   parameter int BURST_W = 16,
   parameter int STOP_W  = 16
) (
   // Clock, reset, enable
   input  wire logic        CLK,
   input  wire logic        RST,
   input  wire logic        CE,
   // AXI4-Lite write channels
   input  wire logic [11:0] AWADDR,
   input  wire logic        AWVALID,
   output logic             AWREADY,
   input  wire logic [31:0] WDATA,
   input  wire logic [3:0]  WSTRB,
   input  wire logic        WVALID,
   output logic             WREADY,
   output logic [1:0]       BRESP,
   output logic             BVALID,
   input  wire logic        BREADY,
   // AXI4-Lite read channels
   input  wire logic [11:0] ARADDR,
   input  wire logic        ARVALID,
   output logic             ARREADY,
   output logic [31:0]      RDATA,
   output logic [1:0]       RRESP,
   output logic             RVALID,
   input  wire logic        RREADY,
   // Acquisition side
   input  wire logic        FIFO_FULL,
   output logic             PACE_CLK,
   output logic             BURST_CLK,
   output logic             CONV_STROBE,
   output logic             STOP_ZERO,
   output logic             RUNNING,
   output logic             PACE_SHUTDOWN
);

   generate
      if (PACE_W != 24 || BURST_W != 16 || STOP_W < 2 || STOP_W > 16) begin : g_chk
         $error("pacing_timers widths unsupported by the register map");
      end
   endgenerate

   // ***************************************************************
   // Register bus slave
   // ***************************************************************
   logic              aw_got_r, aw_got_nxt, w_got_r, w_got_nxt, bvalid_nxt, rvalid_nxt;
   logic [11:0]       waddr_r, waddr_nxt;
   logic [31:0]       wdata_r, wdata_nxt, rdata_nxt;
   logic [3:0]        wstrb_r, wstrb_nxt;
   logic [1:0]        bresp_nxt, rresp_nxt;
   logic              do_wr;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) r[8*i +: 8] = nw[8*i +: 8];
      end
      return r;
   endfunction

   function automatic logic mapped(input logic [11:0] a);
      return a == START_OFF || a == STATUS_OFF || a == PACE_DIV_OFF || a == BURST_DIV_OFF ||
             a == STOP_CNT_OFF || a == MODE_OFF || a == PACE_SEL_OFF || a == BURST_SEL_OFF;
   endfunction

   assign do_wr = aw_got_r && w_got_r && !BVALID;

   always_comb begin
      aw_got_nxt = aw_got_r;
      w_got_nxt  = w_got_r;
      waddr_nxt  = waddr_r;
      wdata_nxt  = wdata_r;
      wstrb_nxt  = wstrb_r;
      bvalid_nxt = BVALID;
      bresp_nxt  = BRESP;
      if (AWVALID && AWREADY) begin
         aw_got_nxt = 1'b1;
         waddr_nxt  = {AWADDR[11:2], 2'b00};
      end
      if (WVALID && WREADY) begin
         w_got_nxt = 1'b1;
         wdata_nxt = WDATA;
         wstrb_nxt = WSTRB;
      end
      if (do_wr) begin
         aw_got_nxt = 1'b0;
         w_got_nxt  = 1'b0;
         bvalid_nxt = 1'b1;
         bresp_nxt  = mapped(waddr_r) ? RESP_OKAY : RESP_SLVERR;
      end else if (BVALID && BREADY) begin
         bvalid_nxt = 1'b0;
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         aw_got_r <= 1'b0;
         w_got_r  <= 1'b0;
         waddr_r  <= 12'h000;
         wdata_r  <= 32'h00000000;
         wstrb_r  <= 4'h0;
         BVALID   <= 1'b0;
         BRESP    <= RESP_OKAY;
         AWREADY  <= 1'b0;
         WREADY   <= 1'b0;
      end else if (CE) begin
         aw_got_r <= aw_got_nxt;
         w_got_r  <= w_got_nxt;
         waddr_r  <= waddr_nxt;
         wdata_r  <= wdata_nxt;
         wstrb_r  <= wstrb_nxt;
         BVALID   <= bvalid_nxt;
         BRESP    <= bresp_nxt;
         AWREADY  <= !aw_got_nxt && !bvalid_nxt;
         WREADY   <= !w_got_nxt && !bvalid_nxt;
      end
   end

   // ***************************************************************
   // Software registers
   // ***************************************************************
   logic [PACE_W-1:0]  pace_div_r, pace_div_nxt;
   logic [BURST_W-1:0] burst_div_r, burst_div_nxt;
   logic [STOP_W-1:0]  stop_load_r, stop_load_nxt;
   mode_s              mode_r, mode_nxt;
   clk_sel_s           sel_r, sel_nxt;
   logic               wr_pace, wr_burst, wr_stop, wr_start, clr_shut;
   logic [31:0]        m;
   logic [31:0]        m_pace, m_burst, m_stop;

   always_comb begin
      m             = merge(32'h00000000, wdata_r, wstrb_r);
      m_pace        = merge(32'(pace_div_r), wdata_r, wstrb_r);
      m_burst       = merge(32'(burst_div_r), wdata_r, wstrb_r);
      m_stop        = merge(32'(stop_load_r), wdata_r, wstrb_r);
      wr_pace       = do_wr && waddr_r == PACE_DIV_OFF;                  // R3
      wr_burst      = do_wr && waddr_r == BURST_DIV_OFF;                 // R8
      wr_stop       = do_wr && waddr_r == STOP_CNT_OFF;                  // R12
      wr_start      = do_wr && waddr_r == START_OFF;
      clr_shut      = do_wr && waddr_r == STATUS_OFF && wstrb_r[0] && wdata_r[STAT_SHUTDOWN_BIT];
      pace_div_nxt  = pace_div_r;
      burst_div_nxt = burst_div_r;
      stop_load_nxt = stop_load_r;
      mode_nxt      = mode_r;
      sel_nxt       = sel_r;
      if (wr_pace) pace_div_nxt = m_pace[PACE_W-1:0];
      if (wr_burst) burst_div_nxt = m_burst[BURST_W-1:0];                // R11
      if (wr_stop) stop_load_nxt = m_stop[STOP_W-1:0];
      if (do_wr && waddr_r == MODE_OFF && wstrb_r[0]) begin
         mode_nxt.stop_sel = m[MODE_STOPSEL_BIT];
         mode_nxt.cycle_en = m[MODE_CYCLE_BIT];
      end
      if (do_wr && waddr_r == PACE_SEL_OFF && wstrb_r[0]) sel_nxt.pace_fast = m[SEL_FAST_BIT];   // R5
      if (do_wr && waddr_r == BURST_SEL_OFF && wstrb_r[0]) sel_nxt.burst_fast = m[SEL_FAST_BIT]; // R10
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         pace_div_r  <= PACE_DIV_RST;
         burst_div_r <= BURST_DIV_RST;
         stop_load_r <= STOP_CNT_RST[STOP_W-1:0];
         mode_r      <= '0;
         sel_r       <= '0;
      end else if (CE) begin
         pace_div_r  <= pace_div_nxt;
         burst_div_r <= burst_div_nxt;
         stop_load_r <= stop_load_nxt;
         mode_r      <= mode_nxt;
         sel_r       <= sel_nxt;
      end
   end

   // ***************************************************************
   // Primary clock ticks
   // ***************************************************************
   // A rate accumulator gives the exact mean 8 or 20 MHz rate; ticks jitter by one system cycle.
   logic [5:0] pacc_r, pacc_nxt, bacc_r, bacc_nxt;
   logic       ptick, btick;
   logic [6:0] psum, bsum;

   always_comb begin
      psum     = 7'(pacc_r) + 7'(sel_r.pace_fast ? FAST_CLK_MHZ : SLOW_CLK_MHZ);
      bsum     = 7'(bacc_r) + 7'(sel_r.burst_fast ? FAST_CLK_MHZ : SLOW_CLK_MHZ);
      ptick    = psum >= 7'(SYS_CLK_MHZ);
      btick    = bsum >= 7'(SYS_CLK_MHZ);
      pacc_nxt = ptick ? 6'(psum - 7'(SYS_CLK_MHZ)) : psum[5:0];
      bacc_nxt = btick ? 6'(bsum - 7'(SYS_CLK_MHZ)) : bsum[5:0];
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         pacc_r <= 6'h00;
         bacc_r <= 6'h00;
      end else if (CE) begin
         pacc_r <= pacc_nxt;
         bacc_r <= bacc_nxt;
      end
   end

   // ***************************************************************
   // Pacing and burst dividers
   // ***************************************************************
   run_state_e state_r, state_nxt;
   logic       pace_pulse;

   div_counter #(.W(PACE_W)) u_pace (                                    // R1
      .clk   (CLK),
      .rst   (RST),
      .ce    (CE),
      .tick  (ptick && state_r == ST_RUN),
      .load  (wr_pace),
      .div   (pace_div_nxt),
      .pulse (pace_pulse)
   );

   div_counter #(.W(BURST_W)) u_burst (                                  // R7
      .clk   (CLK),
      .rst   (RST),
      .ce    (CE),
      .tick  (btick),
      .load  (wr_burst),                                                  // R9
      .div   (burst_div_nxt),
      .pulse (BURST_CLK)
   );

   // ***************************************************************
   // Run control and sample stop counter
   // ***************************************************************
   logic [STOP_W-1:0] stop_cur_r, stop_cur_nxt;
   logic              shut_nxt, conv_nxt, zero_nxt, expire;

   always_comb begin
      state_nxt    = state_r;
      stop_cur_nxt = stop_cur_r;
      conv_nxt     = pace_pulse && state_r == ST_RUN;
      zero_nxt     = 1'b0;
      expire       = 1'b0;
      if (conv_nxt) begin
         if (stop_cur_r == '0) begin
            zero_nxt     = 1'b1;                                          // R16
            stop_cur_nxt = stop_load_r;                                   // R14
            expire       = mode_r.stop_sel && !mode_r.cycle_en;           // R15
         end else begin
            stop_cur_nxt = stop_cur_r - 1'b1;
         end
      end
      if (wr_stop) stop_cur_nxt = stop_load_nxt;                          // R12
      case (state_r)
         ST_IDLE, ST_HALT: if (wr_start) state_nxt = ST_RUN;              // R19
         ST_RUN: begin
            if (FIFO_FULL || expire) state_nxt = ST_HALT;                 // R13
         end
         default: state_nxt = ST_IDLE;
      endcase
      shut_nxt = (PACE_SHUTDOWN && !clr_shut) || (state_r == ST_RUN && FIFO_FULL); // R18
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         state_r       <= ST_IDLE;
         stop_cur_r    <= '0;
         PACE_CLK      <= 1'b0;
         CONV_STROBE   <= 1'b0;
         STOP_ZERO     <= 1'b0;
         RUNNING       <= 1'b0;
         PACE_SHUTDOWN <= 1'b0;
      end else if (CE) begin
         state_r       <= state_nxt;
         stop_cur_r    <= stop_cur_nxt;
         PACE_CLK      <= pace_pulse;
         CONV_STROBE   <= conv_nxt;
         STOP_ZERO     <= zero_nxt;
         RUNNING       <= state_nxt == ST_RUN;
         PACE_SHUTDOWN <= shut_nxt;
      end
   end

   // ***************************************************************
   // Read path
   // ***************************************************************
   always_comb begin
      rvalid_nxt = RVALID;
      rdata_nxt  = RDATA;
      rresp_nxt  = RRESP;
      if (ARVALID && ARREADY) begin
         rvalid_nxt = 1'b1;
         rresp_nxt  = mapped({ARADDR[11:2], 2'b00}) ? RESP_OKAY : RESP_SLVERR;
         rdata_nxt  = 32'h00000000;
         case ({ARADDR[11:2], 2'b00})
            PACE_DIV_OFF:  rdata_nxt = 32'(pace_div_r);
            BURST_DIV_OFF: rdata_nxt = 32'(burst_div_r);
            STOP_CNT_OFF:  rdata_nxt = 32'(stop_cur_r);
            MODE_OFF:      rdata_nxt = 32'({mode_r.cycle_en, mode_r.stop_sel});
            PACE_SEL_OFF:  rdata_nxt = 32'(sel_r.pace_fast);
            BURST_SEL_OFF: rdata_nxt = 32'(sel_r.burst_fast);
            STATUS_OFF: begin
               rdata_nxt[STAT_RUN_BIT]      = RUNNING;
               rdata_nxt[STAT_SHUTDOWN_BIT] = PACE_SHUTDOWN;
            end
            default: rdata_nxt = 32'h00000000;
         endcase
      end else if (RVALID && RREADY) begin
         rvalid_nxt = 1'b0;
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         RVALID  <= 1'b0;
         RDATA   <= 32'h00000000;
         RRESP   <= RESP_OKAY;
         ARREADY <= 1'b0;
      end else if (CE) begin
         RVALID  <= rvalid_nxt;
         RDATA   <= rdata_nxt;
         RRESP   <= rresp_nxt;
         ARREADY <= !rvalid_nxt;
      end
   end

   // ***************************************************************
   // Assertions
   // ***************************************************************
   a_pace_load_pulse: assert property (@(posedge CLK) disable iff (RST) // R4
      CE && wr_pace ##1 CE |-> ##1 PACE_CLK) else $error("pacing divider write gave no pulse");
   a_burst_load_pulse: assert property (@(posedge CLK) disable iff (RST) // R9
      CE && wr_burst |=> BURST_CLK) else $error("burst divider write gave no pulse");
   a_full_halts_run: assert property (@(posedge CLK) disable iff (RST) // R18
      CE && RUNNING && FIFO_FULL && !wr_start |=> PACE_SHUTDOWN && !RUNNING)
      else $error("full buffer did not halt conversions");
   a_shutdown_sticky_hold: assert property (@(posedge CLK) disable iff (RST) // R18
      CE && PACE_SHUTDOWN && !clr_shut |=> PACE_SHUTDOWN) else $error("shutdown flag dropped");
   a_unarmed_no_conv: assert property (@(posedge CLK) disable iff (RST) // R19
      CE && !RUNNING |=> !CONV_STROBE) else $error("conversion while not armed");
   a_stop_expiry_halt: assert property (@(posedge CLK) disable iff (RST) // R13
      CE && expire && !wr_start |=> !RUNNING ##1 !CONV_STROBE) else $error("stop counter expiry did not halt");
   a_cycle_keeps_run: assert property (@(posedge CLK) disable iff (RST) // R14
      CE && zero_nxt && mode_r.cycle_en && !FIFO_FULL && !wr_stop |=> RUNNING && stop_cur_r == $past(stop_load_r))
      else $error("cycling stop counter did not reload");
   a_zero_event_pulse: assert property (@(posedge CLK) disable iff (RST) // R16
      CE && zero_nxt |=> STOP_ZERO && CONV_STROBE) else $error("stop counter zero event missing");
   a_pulse_single: assert property (@(posedge CLK) disable iff (RST) // R20
      CE && ptick && !wr_pace && !$past(wr_pace) && PACE_CLK |=> !PACE_CLK)
      else $error("pacing pulse longer than one cycle");

   c_write_resp: cover property (@(posedge CLK) BVALID && BREADY);
   c_stop_halt: cover property (@(posedge CLK) expire ##1 !RUNNING);
   c_cycle_wrap: cover property (@(posedge CLK) STOP_ZERO && RUNNING);
   c_shutdown: cover property (@(posedge CLK) $rose(PACE_SHUTDOWN));

endmodule
`default_nettype wire

// File: rtl/pacing_pkg.sv
// Package with register map, field positions and types of the acquisition pacing timers.
package pacing_pkg;

   // ***************************************************************
   // Register offsets (byte addresses)
   // ***************************************************************
   localparam logic [11:0] START_OFF      = 12'h010;
   localparam logic [11:0] STATUS_OFF     = 12'h02C;
   localparam logic [11:0] PACE_DIV_OFF   = 12'h040;
   localparam logic [11:0] BURST_DIV_OFF  = 12'h044;
   localparam logic [11:0] STOP_CNT_OFF   = 12'h058;
   localparam logic [11:0] MODE_OFF       = 12'h0E0;
   localparam logic [11:0] PACE_SEL_OFF   = 12'h1DC;
   localparam logic [11:0] BURST_SEL_OFF  = 12'h1E0;

   // ***************************************************************
   // Field positions
   // ***************************************************************
   localparam int STAT_RUN_BIT      = 0;
   localparam int STAT_SHUTDOWN_BIT = 4;
   localparam int MODE_STOPSEL_BIT  = 0;
   localparam int MODE_CYCLE_BIT    = 1;
   localparam int SEL_FAST_BIT      = 0;

   // ***************************************************************
   // Reset values
   // ***************************************************************
   localparam logic [23:0] PACE_DIV_RST  = 24'h000000;
   localparam logic [15:0] BURST_DIV_RST = 16'h0000;
   localparam logic [15:0] STOP_CNT_RST  = 16'h0000;

   // ***************************************************************
   // Timing: primary clocks made from the 50 MHz system clock
   // ***************************************************************
   localparam int SYS_CLK_MHZ  = 50;
   localparam int SLOW_CLK_MHZ = 8;
   localparam int FAST_CLK_MHZ = 20;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_HALT} run_state_e;

   typedef struct packed {
      logic cycle_en;
      logic stop_sel;
   } mode_s;

   typedef struct packed {
      logic pace_fast;
      logic burst_fast;
   } clk_sel_s;

endpackage

// File: rtl/div_counter.sv
// Down-counting divider that emits one pulse per divider plus one primary clock ticks.
`timescale 1ns/1ps
`default_nettype none
module div_counter import pacing_pkg::*; #(
   parameter int W = 16
) (
   // Clocking
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic         ce,
   // Control
   input  wire logic         tick,
   input  wire logic         load,
   input  wire logic [W-1:0] div,
   // Result
   output logic              pulse
);

   logic [W-1:0] cnt_r;
   logic [W-1:0] cnt_nxt;
   logic         pulse_nxt;

   generate
      if (W < 2 || W > 32) begin : g_chk
         $error("div_counter width out of range");
      end
   endgenerate

   always_comb begin
      cnt_nxt   = cnt_r;
      pulse_nxt = 1'b0;
      if (load) begin
         cnt_nxt   = div;                         // R4
         pulse_nxt = 1'b1;
      end else if (tick) begin
         if (cnt_r == '0) begin
            cnt_nxt   = div;                      // R20
            pulse_nxt = 1'b1;
         end else begin
            cnt_nxt = cnt_r - 1'b1;               // R2
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         cnt_r <= '0;
         pulse <= 1'b0;
      end else if (ce) begin
         cnt_r <= cnt_nxt;
         pulse <= pulse_nxt;
      end
   end

endmodule
`default_nettype wire

// File: test/tb.sv
// Self-checking testbench for the acquisition pacing timers.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin fail_count++; $display("ERROR %s exp %0h got %0h", nm, e, g); end end
module tb import pacing_pkg::*;;
   logic        clk, rst, ce, awvalid, wvalid, bready, arvalid, rready, fifo_full;
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata, rdata, d;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp, r;
   logic        awready, wready, bvalid, arready, rvalid;
   logic        pace_clk, burst_clk, conv_strobe, stop_zero, running, pace_shutdown;
   int          fail_count = 0;
   int          n_tests = 0;
   int          n_pace = 0, n_burst = 0, n_conv = 0, n_zero = 0;
   int          s, z;

   pacing_timers u_dut (.CLK(clk), .RST(rst), .CE(ce), .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
      .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp), .BVALID(bvalid),
      .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata), .RRESP(rresp),
      .RVALID(rvalid), .RREADY(rready), .FIFO_FULL(fifo_full), .PACE_CLK(pace_clk), .BURST_CLK(burst_clk),
      .CONV_STROBE(conv_strobe), .STOP_ZERO(stop_zero), .RUNNING(running), .PACE_SHUTDOWN(pace_shutdown));

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   // Pulse outputs last one cycle, so a free-running tally is sampled at every edge.
   always @(posedge clk) begin
      n_pace += (pace_clk === 1'b1);
      n_burst += (burst_clk === 1'b1);
      n_conv += (conv_strobe === 1'b1);
      n_zero += (stop_zero === 1'b1);
   end

   // ***************************************************************
   // Bus tasks and helpers
   // ***************************************************************
   task automatic wr(input logic [11:0] a, input logic [31:0] v);
      logic aw, w;
      aw = 1'b0;
      w = 1'b0;
      @(posedge clk);
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= v;
      wstrb <= 4'hF;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(aw && w)) begin
         @(posedge clk);
         if (!aw && awready === 1'b1) begin
            aw = 1'b1;
            awvalid <= 1'b0;
         end
         if (!w && wready === 1'b1) begin
            w = 1'b1;
            wvalid <= 1'b0;
         end
      end
      do @(posedge clk); while (bvalid !== 1'b1);
      r = bresp;
      bready <= 1'b0;
   endtask

   task automatic rd(input logic [11:0] a);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge clk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge clk); while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask

   task automatic rc(input logic [11:0] a, input logic [31:0] e, input string nm);
      rd(a);
      `CHK(nm, e, d)
   endtask

   function automatic logic sig(input int w);
      return w ? burst_clk : pace_clk;
   endfunction

   // Two whole periods are timed so the uneven primary tick spacing averages out.
   task automatic span(input int w, input int e, input string nm);
      int c;
      repeat (2) do @(posedge clk); while (sig(w) !== 1'b1);
      c = 0;
      repeat (2) do begin
         @(posedge clk);
         c++;
      end while (sig(w) !== 1'b1);
      `CHK(nm, e, (c >= e - 1 && c <= e + 1) ? e : c)
   endtask

   task automatic end_of_test();
      if (fail_count == 0 && n_tests > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   initial begin
      #1000000;
      fail_count++;
      end_of_test();
   end

   // ***************************************************************
   // Test sequence
   // ***************************************************************
   initial begin
      rst = 1'b1;
      ce = 1'b1;
      fifo_full = 1'b0;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
      awaddr = 12'h000;
      araddr = 12'h000;
      wdata = 32'h00000000;
      wstrb = 4'h0;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      `CHK("idle run", 1'b0, running)
      rc(PACE_DIV_OFF, 32'h00000000, "pace reset");
      rc(BURST_DIV_OFF, 32'h00000000, "burst reset");
      rc(STOP_CNT_OFF, 32'h00000000, "stop reset");
      rc(12'h100, 32'h00000000, "unmapped data");
      `CHK("unmapped rresp", RESP_SLVERR, r)
      wr(12'h104, 32'h00000001);
      `CHK("unmapped bresp", RESP_SLVERR, r)
      wr(PACE_DIV_OFF, 32'hFFFFFFFF);
      rc(PACE_DIV_OFF, 32'h00FFFFFF, "pace width");
      wr(BURST_DIV_OFF, 32'hFFFFFFFF);
      rc(BURST_DIV_OFF, 32'h0000FFFF, "burst max");
      wr(STOP_CNT_OFF, 32'h00010005);
      rc(STOP_CNT_OFF, 32'h00000005, "stop width");
      repeat (10) @(posedge clk);
      s = n_pace;
      z = n_burst;
      wr(PACE_DIV_OFF, 32'h00FFFFFE);
      wr(BURST_DIV_OFF, 32'h0000FFFE);
      repeat (10) @(posedge clk);
      `CHK("pace write pulse", 1, n_pace - s)
      `CHK("burst write pulse", 1, n_burst - z)
      `CHK("no sample unarmed", 0, n_conv)
      wr(MODE_OFF, 32'h00000000);
      for (int i = 0; i < 2; i++) begin
         wr(PACE_SEL_OFF, 32'(i));
         wr(BURST_SEL_OFF, 32'(1 - i));
         wr(PACE_DIV_OFF, i ? 32'h0000000F : 32'h00000007);
         wr(BURST_DIV_OFF, 32'h00000007);
         wr(START_OFF, 32'h00000000);
         span(0, i ? 80 : 100, "pace period");
         span(1, i ? 100 : 40, "burst period");
      end
      rc(PACE_SEL_OFF, 32'h00000001, "pace sel");
      rc(BURST_SEL_OFF, 32'h00000000, "burst sel");
      @(posedge clk);
      fifo_full <= 1'b1;
      @(posedge clk);
      fifo_full <= 1'b0;
      repeat (2) @(posedge clk);
      `CHK("full halts", 1'b0, running)
      `CHK("shutdown flag", 1'b1, pace_shutdown)
      s = n_conv;
      repeat (60) @(posedge clk);
      `CHK("no sample halted", 0, n_conv - s)
      rc(STATUS_OFF, 32'h1 << STAT_SHUTDOWN_BIT, "sticky status");
      wr(STATUS_OFF, 32'h1 << STAT_SHUTDOWN_BIT);
      rc(STATUS_OFF, 32'h00000000, "status cleared");
      wr(MODE_OFF, 32'h00000001);
      wr(STOP_CNT_OFF, 32'h00000003);
      s = n_conv;
      z = n_zero;
      wr(START_OFF, 32'h00000000);
      repeat (300) @(posedge clk);
      `CHK("stop samples", 4, n_conv - s)
      `CHK("stop event", 1, n_zero - z)
      rc(STATUS_OFF, 32'h00000000, "stop halted");
      wr(MODE_OFF, 32'h00000003);
      rc(MODE_OFF, 32'h00000003, "mode read");
      wr(STOP_CNT_OFF, 32'h00000001);
      z = n_zero;
      wr(START_OFF, 32'h00000000);
      while (n_zero - z < 2) @(posedge clk);
      `CHK("cycle keeps run", 1'b1, running)
      wr(MODE_OFF, 32'h00000001);
      s = n_conv;
      repeat (200) @(posedge clk);
      `CHK("cycle finish samples", 2, n_conv - s)
      `CHK("cycle finish halt", 1'b0, running)
      `CHK("cycle events", 3, n_zero - z)
      end_of_test();
   end
endmodule
`default_nettype wire
